// ### common/strap_cfg_pkg.sv
`default_nettype none
package strap_cfg_pkg;

  // Timing
  localparam int unsigned CLOCK_FREQ_HZ = 200_000_000;
  localparam int unsigned SLOW_BUS_HZ = 100_000;
  localparam int unsigned FAST_BUS_HZ = 400_000;
  localparam int unsigned SLOW_HALF_CYCLES = CLOCK_FREQ_HZ / (2 * SLOW_BUS_HZ);
  localparam int unsigned FAST_HALF_CYCLES = CLOCK_FREQ_HZ / (2 * FAST_BUS_HZ);
  localparam int unsigned RESET_PROC_CYCLES = 16;

  // Reference clock choice
  localparam int unsigned REF_FREQ_LOW_MHZ = 100;
  localparam int unsigned REF_FREQ_HIGH_MHZ = 125;

  // Register offsets
  localparam logic [7:0] SWITCH_CONTROL_OFS = 8'h00;
  localparam logic [7:0] STRAP_STATUS_OFS = 8'h04;
  localparam logic [7:0] ADDR_STATUS_OFS = 8'h08;
  localparam logic [7:0] GPIO_FUNC_OFS = 8'h0c;
  localparam logic [7:0] GPIO_OUT_OFS = 8'h10;
  localparam logic [7:0] GPIO_OE_OFS = 8'h14;
  localparam logic [7:0] GPIO_IN_OFS = 8'h18;
  localparam logic [7:0] BUS_ACCESS_OFS = 8'h1c;

  // Switch control fields
  localparam int unsigned HOLD_BIT = 0;
  localparam int unsigned EVENT_BIT = 1;
  localparam int unsigned DOWN1_RST_BIT = 2;
  localparam int unsigned DOWN6_RST_BIT = 3;
  localparam int unsigned DOWN7_RST_BIT = 4;
  localparam logic [31:0] SWITCH_CONTROL_RESET = 32'h0000_0000;

  // GPIO pins with alternate functions
  localparam int unsigned GPIO_WIDTH = 13;
  localparam int unsigned GPIO_EXP2_IRQ = 4;
  localparam int unsigned GPIO_EXP3_IRQ = 5;
  localparam int unsigned GPIO_EVENT = 7;
  localparam int unsigned GPIO_DOWN1_RST = 8;
  localparam int unsigned GPIO_DOWN6_RST = 11;
  localparam int unsigned GPIO_DOWN7_RST = 12;
  localparam logic [12:0] GPIO_PRESENT = 13'h19ff;
  localparam logic [12:0] GPIO_FUNC_RESET = 13'h0000;

  // Fixed address bits
  localparam logic [7:0] TARGET_ADDR_FIXED = 8'hc0;
  localparam logic [7:0] EEPROM_ADDR_FIXED = 8'ha0;

  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_NORMAL_EEPROM = 3'h1
  } op_mode_e;

  typedef enum logic [1:0] {
    ST_IN_RESET,
    ST_RESET_PROC,
    ST_HELD,
    ST_RUNNING
  } seq_state_e;

  // Captured straps
  typedef struct packed {
    logic upstream_x8;
    logic port1_active;
    logic down6_x8;
    logic port7_active;
    logic ref_is_125;
    logic shared_down;
    logic shared_up;
    logic slow_bus;
    logic eeprom_load;
    logic mode_reserved;
  } strap_cfg_s;

  localparam logic [9:0] STRAP_CFG_RESET = 10'h000;

endpackage
`default_nettype wire

// ### rtl/switch_strap_reset_config.sv
// Functional notes
// - Port 0 is always the upstream port
// - Combine low: ports 0,1 form x8 upstream
// - Combine high: ports 0,1 separate x4
// - Combine low: ports 6,7 form x8
// - Combine high: ports 6,7 separate x4
// - Frequency select: 0 is 100, 1 is 125 MHz
// - Slow select forces 100 KHz, not overridable
// - Bus clock toggles only during device accesses
// - Fundamental reset clears straps, sequencer and registers (not the bus clock), starts reset
// - Hold strap keeps device in reset, buses alive
// - Clearing hold bit releases device to run
// - Mode 0 normal, 1 EEPROM load, others reserved
// - Downstream shared clock strap is reported
// - Upstream shared clock strap is reported
// - GPIO 4,5 alternate: expander interrupts low
// - GPIO 7 alternate: event output, active low
// - GPIO 8,11,12 alternate: downstream resets low
// - Addresses formed from target and EEPROM straps
// - Addresses sampled at reset release, fixed bits
`default_nettype none
module switch_strap_reset_config
  import strap_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fundamental_reset_n,
  input wire logic reset_hold,
  input wire logic port_zero_one_combine_n,
  input wire logic port_six_seven_combine_n,
  input wire logic ref_freq_select,
  input wire logic master_bus_slow_select,
  input wire logic [2:0] switch_operating_select,
  input wire logic shared_clock_downstream,
  input wire logic shared_clock_upstream,
  input wire logic [4:1] eeprom_addr_straps,
  input wire logic [5:1] target_addr_straps,
  input wire logic [12:0] gpio_in,
  input wire logic bus_access_req,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  output logic [12:0] gpio_out,
  output logic [12:0] gpio_oe,
  output logic master_bus_clock_oe,
  output logic bus_tick,
  output logic core_reset_n,
  output logic device_running,
  output strap_cfg_pkg::strap_cfg_s strap_cfg,
  output logic [7:0] target_addr,
  output logic [7:0] eeprom_addr,
  output logic expander2_irq_n,
  output logic expander3_irq_n
);
  import strap_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [1:0] perst_sync;
  logic [1:0] hold_sync;
  logic [1:0] slow_sync;
  logic [1:0] req_sync;
  logic [12:0] gpio_meta;
  logic [12:0] gpio_sync;
  logic perst_n_s;
  logic hold_s;
  logic slow_s;
  logic req_s;

  // Two flops each for reset, hold, slow select, access request and GPIO pins
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      perst_sync <= 2'h0;
      hold_sync <= 2'h0;
      slow_sync <= 2'h0;
      req_sync <= 2'h0;
      gpio_meta <= 13'h1fff;
      gpio_sync <= 13'h1fff;
    end else begin
      perst_sync <= {perst_sync[0], fundamental_reset_n};
      hold_sync <= {hold_sync[0], reset_hold};
      slow_sync <= {slow_sync[0], master_bus_slow_select};
      req_sync <= {req_sync[0], bus_access_req};
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  assign perst_n_s = perst_sync[1];
  assign hold_s = hold_sync[1];
  assign slow_s = slow_sync[1];
  assign req_s = req_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Reset release edge

  logic perst_n_q;
  logic release_pulse;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      perst_n_q <= 1'b0;
    end else begin
      perst_n_q <= perst_n_s;
    end
  end

  assign release_pulse = perst_n_s & ~perst_n_q;

  ////////////////////////////////////////////////////////////////////////
  // Strap decode and capture

  strap_cfg_s next_strap_cfg;
  logic [7:0] next_target_addr;
  logic [7:0] next_eeprom_addr;
  wire mode_is_normal = (switch_operating_select == MODE_NORMAL);
  wire mode_is_eeprom = (switch_operating_select == MODE_NORMAL_EEPROM);

  assign next_strap_cfg.upstream_x8 = ~port_zero_one_combine_n;
  assign next_strap_cfg.port1_active = port_zero_one_combine_n;
  assign next_strap_cfg.down6_x8 = ~port_six_seven_combine_n;
  assign next_strap_cfg.port7_active = port_six_seven_combine_n;
  assign next_strap_cfg.ref_is_125 = ref_freq_select;
  assign next_strap_cfg.shared_down = shared_clock_downstream;
  assign next_strap_cfg.shared_up = shared_clock_upstream;
  assign next_strap_cfg.slow_bus = slow_s;
  assign next_strap_cfg.eeprom_load = mode_is_eeprom;
  assign next_strap_cfg.mode_reserved = ~(mode_is_normal | mode_is_eeprom);

  // Fixed bits merged with strap bits
  assign next_target_addr = TARGET_ADDR_FIXED | {2'h0, target_addr_straps[5], 1'b0,
                            target_addr_straps[3:1], 1'b0};
  assign next_eeprom_addr = EEPROM_ADDR_FIXED | {3'h0, eeprom_addr_straps[4:1], 1'b0};

  // Captured on release, held until next reset
  always_ff @(posedge clock) begin
    if (!rst_n || !perst_n_s) begin
      strap_cfg <= STRAP_CFG_RESET;
      target_addr <= TARGET_ADDR_FIXED;
      eeprom_addr <= EEPROM_ADDR_FIXED;
    end else if (release_pulse) begin
      strap_cfg <= next_strap_cfg;
      target_addr <= next_target_addr;
      eeprom_addr <= next_eeprom_addr;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencer

  seq_state_e state;
  seq_state_e next_state;
  logic [4:0] proc_count;
  logic hold_latched;
  logic hold_bit;
  wire proc_done = (proc_count == 5'(RESET_PROC_CYCLES - 1));

  always_comb begin
    next_state = state;
    case (state)
      ST_IN_RESET: begin
        if (release_pulse) begin
          next_state = ST_RESET_PROC;
        end
      end
      ST_RESET_PROC: begin
        if (proc_done) begin
          next_state = hold_latched ? ST_HELD : ST_RUNNING;
        end
      end
      ST_HELD: begin
        if (!hold_bit) begin
          next_state = ST_RUNNING;
        end
      end
      ST_RUNNING: begin
        next_state = ST_RUNNING;
      end
      default: begin
        next_state = ST_IN_RESET;
      end
    endcase
  end

  // Hold strap sampled while fundamental reset is asserted
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= ST_IN_RESET;
      proc_count <= 5'h00;
      hold_latched <= 1'b0;
    end else if (!perst_n_s) begin
      state <= ST_IN_RESET;
      proc_count <= 5'h00;
      hold_latched <= hold_s;
    end else begin
      state <= next_state;
      proc_count <= (state == ST_RESET_PROC) ? proc_count + 5'h01 : 5'h00;
    end
  end

  // Core held in reset until running
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      core_reset_n <= 1'b0;
      device_running <= 1'b0;
    end else begin
      core_reset_n <= (next_state == ST_RUNNING) && perst_n_s;
      device_running <= (next_state == ST_RUNNING) && perst_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file

  logic [31:0] switch_control;
  logic [12:0] gpio_func;
  logic [12:0] gpio_out_reg;
  logic [12:0] gpio_oe_reg;
  logic [31:0] next_rdata;
  wire wr_ctrl = reg_write && (reg_addr == SWITCH_CONTROL_OFS);
  wire wr_func = reg_write && (reg_addr == GPIO_FUNC_OFS);
  wire wr_gout = reg_write && (reg_addr == GPIO_OUT_OFS);
  wire wr_goe = reg_write && (reg_addr == GPIO_OE_OFS);

  assign hold_bit = switch_control[HOLD_BIT];

  // Registers stay writable while held, cleared by reset
  always_ff @(posedge clock) begin
    if (!rst_n || !perst_n_s) begin
      switch_control <= SWITCH_CONTROL_RESET;
      gpio_func <= GPIO_FUNC_RESET;
      gpio_out_reg <= 13'h0000;
      gpio_oe_reg <= 13'h0000;
    end else begin
      if (release_pulse) begin
        switch_control[HOLD_BIT] <= hold_latched;
      end else if (wr_ctrl) begin
        switch_control <= {27'h0, reg_wdata[4:0]};
      end
      if (wr_func) begin
        gpio_func <= reg_wdata[12:0] & GPIO_PRESENT;
      end
      if (wr_gout) begin
        gpio_out_reg <= reg_wdata[12:0] & GPIO_PRESENT;
      end
      if (wr_goe) begin
        gpio_oe_reg <= reg_wdata[12:0] & GPIO_PRESENT;
      end
    end
  end

  // Read decode, unmapped reads zero
  always_comb begin
    case (reg_addr)
      SWITCH_CONTROL_OFS: next_rdata = switch_control;
      STRAP_STATUS_OFS: next_rdata = {17'h0, state, strap_cfg, switch_operating_select};
      ADDR_STATUS_OFS: next_rdata = {16'h0, eeprom_addr, target_addr};
      GPIO_FUNC_OFS: next_rdata = {19'h0, gpio_func};
      GPIO_OUT_OFS: next_rdata = {19'h0, gpio_out_reg};
      GPIO_OE_OFS: next_rdata = {19'h0, gpio_oe_reg};
      GPIO_IN_OFS: next_rdata = {19'h0, gpio_sync};
      BUS_ACCESS_OFS: next_rdata = {31'h0, master_bus_clock_oe};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Master bus clock rate

  logic [9:0] rate_count;
  wire [9:0] half_period = slow_s ? 10'(SLOW_HALF_CYCLES - 1) : 10'(FAST_HALF_CYCLES - 1);
  wire rate_wrap = (rate_count >= half_period);

  // Tick only while an access is in progress
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rate_count <= 10'h000;
      bus_tick <= 1'b0;
      master_bus_clock_oe <= 1'b0;
    end else begin
      master_bus_clock_oe <= req_s;
      if (!req_s) begin
        rate_count <= 10'h000;
        bus_tick <= 1'b0;
      end else begin
        rate_count <= rate_wrap ? 10'h000 : rate_count + 10'h001;
        bus_tick <= rate_wrap;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // GPIO alternate functions

  logic [12:0] next_gpio_out;
  logic [12:0] next_gpio_oe;
  logic [12:0] alt_value;
  logic [12:0] alt_is_out;

  // Alternate outputs, all active low
  always_comb begin
    alt_value = 13'h1fff;
    alt_is_out = 13'h0000;
    alt_value[GPIO_EVENT] = ~switch_control[EVENT_BIT];
    alt_value[GPIO_DOWN1_RST] = ~(switch_control[DOWN1_RST_BIT] | ~core_reset_n);
    alt_value[GPIO_DOWN6_RST] = ~(switch_control[DOWN6_RST_BIT] | ~core_reset_n);
    alt_value[GPIO_DOWN7_RST] = ~(switch_control[DOWN7_RST_BIT] | ~core_reset_n);
    alt_is_out[GPIO_EVENT] = 1'b1;
    alt_is_out[GPIO_DOWN1_RST] = 1'b1;
    alt_is_out[GPIO_DOWN6_RST] = 1'b1;
    alt_is_out[GPIO_DOWN7_RST] = 1'b1;
  end

  genvar g;
  generate
    for (g = 0; g < GPIO_WIDTH; g++) begin : gpio_mux
      assign next_gpio_out[g] = gpio_func[g] ? alt_value[g] : gpio_out_reg[g];
      assign next_gpio_oe[g] = gpio_func[g] ? alt_is_out[g] : gpio_oe_reg[g];
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      gpio_out <= 13'h0000;
      gpio_oe <= 13'h0000;
      expander2_irq_n <= 1'b1;
      expander3_irq_n <= 1'b1;
    end else begin
      gpio_out <= next_gpio_out;
      gpio_oe <= next_gpio_oe;
      expander2_irq_n <= ~gpio_func[GPIO_EXP2_IRQ] | gpio_sync[GPIO_EXP2_IRQ];
      expander3_irq_n <= ~gpio_func[GPIO_EXP3_IRQ] | gpio_sync[GPIO_EXP3_IRQ];
    end
  end

endmodule
`default_nettype wire

// ### verification/board_source.sv
`default_nettype none
module board_source
  import strap_cfg_pkg::*;
#(
  parameter int RESET_LEN = 8
)(
  input wire logic clock,
  input wire logic reset_req,
  input wire logic [2:0] mode_next,
  input wire logic [12:0] pin_low,
  input wire logic [12:0] gpio_out,
  input wire logic [12:0] gpio_oe,
  output logic fundamental_reset_n,
  output logic [2:0] switch_operating_select,
  output logic [12:0] gpio_in
);
  timeunit 1ns;
  timeprecision 1ps;
  int count = 0;
  initial switch_operating_select = 3'h0;
  // Reset source holds its pin low for a fixed span
  always @(posedge clock) begin
    if (reset_req) count <= RESET_LEN;
    else if (count > 0) count <= count - 1;
  end
  assign fundamental_reset_n = (count == 0);
  // Mode straps move only while reset is held
  always @(posedge clock) begin
    if (!fundamental_reset_n || reset_req) switch_operating_select <= mode_next;
  end
  // Pull-ups keep undriven pins high
  assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ~pin_low);
endmodule
`default_nettype wire

// ### verification/strap_checks_asserts.sv
`default_nettype none
module strap_checks
  import strap_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fundamental_reset_n,
  input wire logic bus_access_req,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata,
  input wire logic master_bus_clock_oe,
  input wire logic bus_tick,
  input wire logic core_reset_n,
  input wire logic device_running,
  input wire strap_cfg_s strap_cfg,
  input wire logic [7:0] target_addr,
  input wire logic [7:0] eeprom_addr
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  // Register port and sequencer
  property p_rd_idle; !reg_read |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its slot");
  property p_pair; core_reset_n == device_running; endproperty
  a_pair: assert property (p_pair) else $error("core reset and running disagree");
  property p_fr; !fundamental_reset_n [*4] |=> !device_running && strap_cfg == '0; endproperty
  a_fr: assert property (p_fr) else $error("fundamental reset not honoured");
  property p_hold; $past(device_running) && device_running |-> $stable(strap_cfg); endproperty
  a_hold: assert property (p_hold) else $error("captured straps moved");
  property p_merge;
    device_running |-> strap_cfg.upstream_x8 != strap_cfg.port1_active &&
      strap_cfg.down6_x8 != strap_cfg.port7_active && !(strap_cfg.eeprom_load && strap_cfg.mode_reserved);
  endproperty
  a_merge: assert property (p_merge) else $error("inconsistent port or mode decode");
  property p_addr;
    target_addr[7:6] == 2'b11 && !target_addr[4] && eeprom_addr[7:5] == 3'b101;
  endproperty
  a_addr: assert property (p_addr) else $error("fixed address bits wrong");
  ////////////////////////////////////////////////////////////
  // Master bus clock
  property p_oe_on; bus_access_req [*4] |-> master_bus_clock_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("bus clock not enabled");
  property p_oe_off; !bus_access_req [*4] |-> !master_bus_clock_oe && !bus_tick; endproperty
  a_oe_off: assert property (p_oe_off) else $error("bus clock active while idle");
  property p_gap; $rose(bus_tick) |=> !bus_tick [*8]; endproperty
  a_gap: assert property (p_gap) else $error("bus ticks too close");
  c_run: cover property ($rose(device_running));
  c_tick: cover property (bus_tick);
  c_read: cover property (reg_read ##1 reg_rdata != 32'h0);
endmodule
bind switch_strap_reset_config strap_checks u_chk (.clock(clock), .rst_n(rst_n),
  .fundamental_reset_n(fundamental_reset_n), .bus_access_req(bus_access_req), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .master_bus_clock_oe(master_bus_clock_oe), .bus_tick(bus_tick),
  .core_reset_n(core_reset_n), .device_running(device_running), .strap_cfg(strap_cfg),
  .target_addr(target_addr), .eeprom_addr(eeprom_addr));
`default_nettype wire

// ### verification/testbench.sv
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got %h exp %h", $time, a, b); end end
module testbench
  import strap_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, hold = 0, p01_n = 0, p67_n = 0, ref_sel = 0, slow = 0, sh_dn = 0, sh_up = 0;
  logic bus_req = 0, reg_write = 0, reg_read = 0, reset_req = 0, oe, tick, core_n, running, irq2, irq3, fr_n;
  logic [2:0] mode_next = 0, mode;
  logic [4:1] ee_s = 0;
  logic [5:1] tg_s = 0;
  logic [12:0] pin_low = 0, gpio_out, gpio_oe, gpio_in;
  logic [7:0] reg_addr = 0, taddr, eaddr;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [9:0] exp_cfg;
  strap_cfg_s cfg;
  int num_errors = 0, samples_checked = 0, seed = 32'hd40a, n;
  always #2.5 clock = ~clock;
  ////////////////////////////////////////////////////////////
  switch_strap_reset_config dut (.clock(clock), .rst_n(rst_n), .fundamental_reset_n(fr_n), .reset_hold(hold),
    .port_zero_one_combine_n(p01_n), .port_six_seven_combine_n(p67_n), .ref_freq_select(ref_sel),
    .master_bus_slow_select(slow), .switch_operating_select(mode), .shared_clock_downstream(sh_dn),
    .shared_clock_upstream(sh_up), .eeprom_addr_straps(ee_s), .target_addr_straps(tg_s), .gpio_in(gpio_in),
    .bus_access_req(bus_req), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .master_bus_clock_oe(oe), .bus_tick(tick), .core_reset_n(core_n), .device_running(running),
    .strap_cfg(cfg), .target_addr(taddr), .eeprom_addr(eaddr), .expander2_irq_n(irq2), .expander3_irq_n(irq3));
  board_source #(.RESET_LEN(8)) board (.clock(clock), .reset_req(reset_req), .mode_next(mode_next),
    .pin_low(pin_low), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .fundamental_reset_n(fr_n),
    .switch_operating_select(mode), .gpio_in(gpio_in));
  ////////////////////////////////////////////////////////////
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock) {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clock) reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock) {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clock) reg_read <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  // Fundamental reset with fresh straps, then decode checks
  task automatic boot(input int i);
    @(posedge clock) {p01_n, p67_n, ref_sel, slow, sh_dn, sh_up} <= 6'($random(seed));
    {tg_s, ee_s, mode_next, hold, reset_req} <= {5'($random(seed)), 4'($random(seed)), 3'(i), i == 3, 1'b1};
    @(posedge clock) reset_req <= 1'b0;
    repeat (6) @(posedge clock);
    #1 `CHK({running, cfg}, 11'h0)
    repeat (40) @(posedge clock);
    #1 exp_cfg = {~p01_n, p01_n, ~p67_n, p67_n, ref_sel, sh_dn, sh_up, slow, i == 1, i > 1};
    `CHK(cfg, exp_cfg)
    `CHK({taddr, eaddr}, {2'b11, tg_s[5], 1'b0, tg_s[3:1], 1'b0, 3'b101, ee_s, 1'b0})
    `CHK(running, i != 3)
    rd(STRAP_STATUS_OFS, 32'({i == 3 ? 2'd2 : 2'd3, exp_cfg, 3'(i)}));
    rd(ADDR_STATUS_OFS, {16'h0, 3'b101, ee_s, 1'b0, 2'b11, tg_s[5], 1'b0, tg_s[3:1], 1'b0});
    if (i == 3) begin
      wr(SWITCH_CONTROL_OFS, 32'h0);
      repeat (2) @(posedge clock);
      #1 `CHK(core_n, 1'b1)
    end
    @(posedge clock) {p01_n, p67_n, ref_sel, sh_dn, sh_up} <= ~{p01_n, p67_n, ref_sel, sh_dn, sh_up};
    repeat (5) @(posedge clock);
    #1 `CHK(cfg, exp_cfg)
  endtask
  // Spacing of master bus ticks at one speed
  task automatic tick_gap(input logic s, input int e);
    @(posedge clock) {slow, bus_req} <= {s, 1'b1};
    n = 0;
    do begin @(posedge clock); #1 n++; end while (!tick && n < 3000);
    n = 0;
    do begin @(posedge clock); #1 n++; end while (!tick && n < 3000);
    `CHK(n, e)
    `CHK(oe, 1'b1)
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    repeat (40000) @(posedge clock);
    num_errors++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) boot(i);
    rd(8'h20, 32'h0);
    wr(GPIO_FUNC_OFS, 32'h19b0);
    for (int k = 0; k < 4; k++) begin
      wr(SWITCH_CONTROL_OFS, 32'h2 << k);
      repeat (2) @(posedge clock);
      #1 `CHK({gpio_out[12:11], gpio_out[8:7], gpio_oe[12:11], gpio_oe[8:7]}, {~(4'h1 << k), 4'hf})
    end
    @(posedge clock) pin_low <= 13'h0010;
    repeat (4) @(posedge clock);
    #1 `CHK({irq2, irq3}, 2'b01)
    @(posedge clock) pin_low <= 13'h0020;
    repeat (4) @(posedge clock);
    #1 `CHK({irq2, irq3}, 2'b10)
    wr(GPIO_FUNC_OFS, 32'h0);
    repeat (4) @(posedge clock);
    #1 `CHK(irq3, 1'b1)
    // Plain GPIO drive and readback once alternates are off
    wr(GPIO_OE_OFS, 32'h3);
    wr(GPIO_OUT_OFS, 32'hffff_fffc);
    rd(GPIO_OUT_OFS, 32'(GPIO_PRESENT & 13'h1ffc));
    repeat (3) @(posedge clock);
    rd(GPIO_IN_OFS, 32'h1fdc);
    #1 `CHK({gpio_out[1:0], gpio_oe[1:0]}, 4'h3)
    tick_gap(1'b1, SLOW_HALF_CYCLES);
    tick_gap(1'b0, FAST_HALF_CYCLES);
    rd(BUS_ACCESS_OFS, 32'h1);
    @(posedge clock) bus_req <= 1'b0;
    repeat (5) @(posedge clock);
    #1 `CHK({oe, tick}, 2'b00)
    rd(BUS_ACCESS_OFS, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire
